// ### include/ipr_defs.svh
// offsets, field positions, reset values and timing in ns for the request word and its controller
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// ==========================================================
// views of the request word
`define IPR_POLL_VIEW 1'h0
`define IPR_ACCEPT_VIEW 1'h1
`define IPR_PRIO_MSB 31
`define IPR_PRIO_LSB 24
`define IPR_SRC_MSB 23
`define IPR_SRC_LSB 0
`define IPR_PRIO_RESET 8'h00
`define IPR_SRC_NONE 24'h000000

// ==========================================================
// timing
`define IPR_CLK_PERIOD_NS 25
`define IPR_LINE_DROP_NS 50

// ==========================================================
// controller registers (byte addresses)
`define CTL_OP_ADDR 5'h00
`define CTL_DATA_ADDR 5'h04
`define CTL_RESULT_ADDR 5'h08
`define CTL_STATUS_ADDR 5'h0C
`define CTL_ENABLE_ADDR 5'h10
`define ST_BUSY_BIT 0
`define ST_LINE_BIT 1
`define ST_ENABLE_BIT 2
`define ST_TAKEN_BIT 3
`define ST_MATCH_BIT 4
`define ST_SPURIOUS_BIT 5

`endif

// ### include/ipr_pkg.sv
// types shared by both ends of the request word link
package ipr_pkg;

	typedef logic [7:0] priority_t;

	// source identifier, most significant field first
	typedef struct packed {
		logic [10:0] impl_field;
		logic [8:0] unit_identifier;
		logic [3:0] source_number;
	} source_id_s;

	typedef enum logic [1:0] {
		OP_POLL_LOAD = 2'b00,
		OP_ACCEPT_LOAD = 2'b01,
		OP_PRIORITY_STORE = 2'b10,
		OP_COMPLETION_STORE = 2'b11
	} op_e;

	// smaller byte wins; all ones is least favored
	function automatic logic more_favored(input priority_t a, input priority_t b);
		more_favored = a < b;
	endfunction

endpackage

// ### include/ipr_if.sv
// load/store link between the processor and its presentation logic
`timescale 1ns/1ps
interface ipr_if;
	logic req_load;
	logic req_store;
	logic req_accept_view;
	logic req_word;
	logic [31:0] req_data;
	logic rsp_valid;
	logic [31:0] rsp_data;
	logic int_line;

	modport device (
		input req_load,
		input req_store,
		input req_accept_view,
		input req_word,
		input req_data,
		output rsp_valid,
		output rsp_data,
		output int_line
	);

	modport processor (
		output req_load,
		output req_store,
		output req_accept_view,
		output req_word,
		output req_data,
		input rsp_valid,
		input rsp_data,
		input int_line
	);
endinterface

// ### verilog/offer_arbiter.sv
// decides whether a routing offer is presented and whether it preempts
`timescale 1ns/1ps
`include "ipr_defs.svh"
module offer_arbiter (
	input wire logic [23:0] offer_id,
	input wire logic [7:0] offer_prio,
	input wire logic [7:0] current_priority,
	input wire logic [7:0] presented_prio,
	input wire logic held,
	output logic take,
	output logic preempt
);
	// ==========================================================
	// comparisons
	wire over_current = ipr_pkg::more_favored(offer_prio, current_priority);
	wire over_held = ipr_pkg::more_favored(offer_prio, presented_prio);
	wire nonzero = offer_id != `IPR_SRC_NONE;

	// a held source only yields to a strictly more favored one
	assign take = nonzero & over_current & (~held | over_held);
	assign preempt = take & held;
endmodule

// ### verilog/request_word_device.sv
// per-processor request word: poll view, accepting view, routing side
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "ipr_defs.svh"
module request_word_device #(
	parameter bit LATCH_LINE = 1'b1,
	parameter int DROP_NS = `IPR_LINE_DROP_NS
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	ipr_if.device bus,
	input wire logic offer_valid,
	input wire logic [23:0] offer_id,
	input wire logic [7:0] offer_prio,
	output logic offer_taken,
	output logic offer_reject,
	output logic reject_valid,
	output logic [23:0] reject_id,
	output logic completion_reset,
	output logic [23:0] completion_id,
	output logic [7:0] completion_level
);
	// ==========================================================
	// timing
	// least time, so round up; never below one cycle
	localparam int DROP_RAW = (DROP_NS + `IPR_CLK_PERIOD_NS - 1) / `IPR_CLK_PERIOD_NS;
	localparam int DROP_CYCLES = (DROP_RAW < 1) ? 1 : DROP_RAW;
	localparam logic [7:0] DROP_LAST = 8'(DROP_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DROP = 2'b01
	} state_e;

	// ==========================================================
	// state
	state_e state;
	logic [7:0] drop_cnt;
	ipr_pkg::priority_t current_priority;
	ipr_pkg::source_id_s source_identifier;
	ipr_pkg::priority_t presented_prio;
	logic line;

	// ==========================================================
	// request decode
	wire idle = state == ST_IDLE;
	wire any_req = bus.req_load | bus.req_store;
	wire poll_load = idle & bus.req_load & (bus.req_accept_view == `IPR_POLL_VIEW);
	wire accept_load = idle & bus.req_load & (bus.req_accept_view == `IPR_ACCEPT_VIEW);
	wire view4_store = idle & bus.req_store & (bus.req_accept_view == `IPR_ACCEPT_VIEW);
	wire prio_store = view4_store & ~bus.req_word;
	wire completion_store = view4_store & bus.req_word;
	wire [7:0] store_prio = bus.req_data[`IPR_PRIO_MSB:`IPR_PRIO_LSB];
	wire [23:0] store_src = bus.req_data[`IPR_SRC_MSB:`IPR_SRC_LSB];
	wire [23:0] held_src = source_identifier;
	wire held = held_src != `IPR_SRC_NONE;
	wire [31:0] word_now = {current_priority, held_src};

	// a held request no longer more favored than the new priority goes back
	wire store_drop = prio_store & held & ~ipr_pkg::more_favored(presented_prio, store_prio);

	// offers wait while any load or store is in hand, so pulses never collide
	wire offer_live = offer_valid & ~offer_taken & ~offer_reject & idle & ~any_req;

	wire take;
	wire preempt;

	// ==========================================================
	// offer arbitration
	offer_arbiter arbiter (
		.offer_id(offer_id),
		.offer_prio(offer_prio),
		.current_priority(current_priority),
		.presented_prio(presented_prio),
		.held(held),
		.take(take),
		.preempt(preempt)
	);

	assign bus.int_line = line;

	// ==========================================================
	// accept sequence state machine
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			drop_cnt <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (accept_load) begin
						state <= ST_DROP;
						drop_cnt <= DROP_LAST;
					end
				end
				ST_DROP: begin
					if (drop_cnt == 8'h00) begin
						state <= ST_IDLE;
					end else begin
						drop_cnt <= drop_cnt - 8'h01;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// load answers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.rsp_valid <= 1'b0;
			bus.rsp_data <= 32'h00000000;
		end else begin
			bus.rsp_valid <= 1'b0;
			if (poll_load) begin
				bus.rsp_valid <= 1'b1;
				bus.rsp_data <= word_now;
			end else if (state == ST_DROP && drop_cnt == 8'h00) begin
				// line has been low long enough; zero here marks a phantom
				bus.rsp_valid <= 1'b1;
				bus.rsp_data <= word_now;
			end
		end
	end

	// ==========================================================
	// priority and source identifier
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			current_priority <= `IPR_PRIO_RESET;
			source_identifier <= `IPR_SRC_NONE;
			presented_prio <= 8'hFF;
		end else if (state == ST_DROP && drop_cnt == 8'h00) begin
			// after the transfer, same edge as the answer is registered
			if (held) begin
				current_priority <= presented_prio;
			end
			source_identifier <= `IPR_SRC_NONE;
		end else if (prio_store) begin
			current_priority <= store_prio;
			if (store_drop) begin
				source_identifier <= `IPR_SRC_NONE;
			end
		end else if (completion_store) begin
			// identifier in the data only names the source to reset
			current_priority <= store_prio;
		end else if (offer_live && take) begin
			// never reached during the accept sequence: offers need idle
			source_identifier <= offer_id;
			presented_prio <= offer_prio;
		end
	end

	// ==========================================================
	// interrupt line
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line <= 1'b0;
		end else if (accept_load) begin
			line <= 1'b0;
		end else if (offer_live && take) begin
			line <= 1'b1;
		end else if (store_drop && !LATCH_LINE) begin
			line <= 1'b0;
		end
	end

	// ==========================================================
	// routing side answers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			offer_taken <= 1'b0;
			offer_reject <= 1'b0;
			reject_valid <= 1'b0;
			reject_id <= `IPR_SRC_NONE;
		end else begin
			offer_taken <= offer_live & take;
			offer_reject <= offer_live & ~take;
			reject_valid <= 1'b0;
			if (store_drop) begin
				reject_valid <= 1'b1;
				reject_id <= held_src;
			end else if (offer_live && preempt) begin
				reject_valid <= 1'b1; // preempted source is offered again later
				reject_id <= held_src;
			end else if (offer_live && !take) begin
				reject_valid <= 1'b1;
				reject_id <= offer_id;
			end
		end
	end

	// ==========================================================
	// completion resets; poll-view stores fall through untouched
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			completion_reset <= 1'b0;
			completion_id <= `IPR_SRC_NONE;
			completion_level <= 8'hFF;
		end else begin
			completion_reset <= completion_store;
			if (completion_store) begin
				// no rejection here: the new priority is never more favored
				completion_id <= store_src;
				completion_level <= store_prio;
			end
		end
	end
endmodule

// ### verilog/processor_end.sv
// processor end: issues loads and stores on software command, takes interrupts
`timescale 1ns/1ps
`include "ipr_defs.svh"
module processor_end (
	input wire logic ref_clk,
	input wire logic sys_rst,
	ipr_if.processor bus,
	input wire logic [4:0] addr,
	input wire logic [31:0] wdata,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [31:0] rdata,
	output logic irq_out
);
	// ==========================================================
	// controller state
	logic [31:0] store_data;
	logic [31:0] result;
	logic [23:0] last_poll_id;
	logic busy;
	logic accept_pending;
	logic poll_pending;
	logic external_enable_bit;
	logic id_match;
	logic spurious;

	// ==========================================================
	// decode
	wire op_write = write_strobe & (addr == `CTL_OP_ADDR) & ~busy;
	wire data_write = write_strobe & (addr == `CTL_DATA_ADDR);
	wire enable_write = write_strobe & (addr == `CTL_ENABLE_ADDR);
	wire [1:0] op = wdata[1:0];
	wire is_load = (op == ipr_pkg::OP_POLL_LOAD) | (op == ipr_pkg::OP_ACCEPT_LOAD);
	wire take_irq = bus.int_line & external_enable_bit;
	wire [23:0] rsp_src = bus.rsp_data[`IPR_SRC_MSB:`IPR_SRC_LSB];
	wire [31:0] status = {26'h0000000, spurious, id_match, irq_out,
		external_enable_bit, bus.int_line, busy};
	wire [31:0] read_mux = (addr == `CTL_DATA_ADDR) ? store_data :
		(addr == `CTL_RESULT_ADDR) ? result :
		(addr == `CTL_STATUS_ADDR) ? status :
		(addr == `CTL_ENABLE_ADDR) ? {31'h00000000, external_enable_bit} : 32'h00000000;

	// ==========================================================
	// link requests, one cycle each
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.req_load <= 1'b0;
			bus.req_store <= 1'b0;
			bus.req_accept_view <= 1'b0;
			bus.req_word <= 1'b0;
			bus.req_data <= 32'h00000000;
		end else begin
			bus.req_load <= op_write & is_load;
			bus.req_store <= op_write & ~is_load;
			if (op_write) begin
				bus.req_accept_view <= op != ipr_pkg::OP_POLL_LOAD;
				bus.req_word <= op == ipr_pkg::OP_COMPLETION_STORE;
				// byte store carries the priority in lane 0 only
				bus.req_data <= (op == ipr_pkg::OP_PRIORITY_STORE) ?
					{store_data[31:24], 24'h000000} : store_data;
			end
		end
	end

	// ==========================================================
	// answers and identifier checks
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'b0;
			accept_pending <= 1'b0;
			poll_pending <= 1'b0;
			result <= 32'h00000000;
			last_poll_id <= 24'h000000;
			id_match <= 1'b0;
			spurious <= 1'b0;
		end else if (op_write) begin
			busy <= is_load;
			accept_pending <= op == ipr_pkg::OP_ACCEPT_LOAD;
			poll_pending <= op == ipr_pkg::OP_POLL_LOAD;
		end else if (bus.rsp_valid) begin
			busy <= 1'b0;
			accept_pending <= 1'b0;
			poll_pending <= 1'b0;
			result <= bus.rsp_data;
			if (poll_pending) begin
				last_poll_id <= rsp_src;
			end
			if (accept_pending) begin
				id_match <= rsp_src == last_poll_id;
				spurious <= rsp_src == `IPR_SRC_NONE;
			end
		end
	end

	// ==========================================================
	// enable bit and interrupt taking
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			external_enable_bit <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			if (take_irq) begin
				// taking wins over a same-cycle enable write
				external_enable_bit <= 1'b0;
				irq_out <= 1'b1;
			end else if (enable_write && !accept_pending) begin
				// an enable write is dropped while the accept data has not yet returned
				external_enable_bit <= wdata[0];
			end
			if (op_write && op == ipr_pkg::OP_ACCEPT_LOAD && !take_irq) begin
				irq_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// register port
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			store_data <= 32'h00000000;
			rdata <= 32'h00000000;
		end else begin
			if (data_write) begin
				store_data <= wdata;
			end
			rdata <= read_strobe ? read_mux : 32'h00000000;
		end
	end
endmodule

// ### tb/request_word_checker.sv
// concurrent checks on the request word link between the two ends
`timescale 1ns/1ps
module request_word_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_load,
	input wire logic req_store,
	input wire logic req_accept_view,
	input wire logic req_word,
	input wire logic [31:0] req_data,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_data,
	input wire logic int_line
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic acc_pend;
	logic acc_done;
	// ==========================================================
	// helper state
	// remembers an accept answer until a fresh line rises again
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_pend <= 1'b0;
			acc_done <= 1'b0;
		end else begin
			acc_pend <= (req_load && req_accept_view) || (acc_pend && !rsp_valid);
			acc_done <= (rsp_valid && acc_pend) || (acc_done && !int_line);
		end
	end
	// ==========================================================
	// properties
	property p_poll_answer;
		req_load && !req_accept_view |=> rsp_valid;
	endproperty
	property p_accept_drop;
		req_load && req_accept_view |=> !int_line;
	endproperty
	property p_accept_wait;
		req_load && req_accept_view |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid;
	endproperty
	property p_no_cancel;
		req_load && req_accept_view |=> !int_line [*3];
	endproperty
	property p_rsp_pulse;
		rsp_valid |=> !rsp_valid;
	endproperty
	property p_rsp_hold;
		!rsp_valid |-> $stable(rsp_data);
	endproperty
	property p_poll_keep;
		req_load && !req_accept_view && int_line |=> int_line;
	endproperty
	property p_cleared_id;
		req_load && !req_accept_view && acc_done ##1 !int_line |-> rsp_data[23:0] == 24'h000000;
	endproperty
	a_poll_answer: assert property (p_poll_answer) else $error("poll load not answered");
	a_accept_drop: assert property (p_accept_drop) else $error("line kept on accept");
	a_accept_wait: assert property (p_accept_wait) else $error("accept answer timing");
	a_no_cancel: assert property (p_no_cancel) else $error("line rose during accept");
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than one cycle");
	a_rsp_hold: assert property (p_rsp_hold) else $error("answer data moved");
	a_poll_keep: assert property (p_poll_keep) else $error("poll dropped the line");
	a_cleared_id: assert property (p_cleared_id) else $error("identifier not cleared");
	// main traffic seen at least once
	c_poll: cover property (req_load && !req_accept_view);
	c_accept: cover property (req_load && req_accept_view ##3 rsp_data[23:0] != 24'h000000);
	c_store: cover property (req_store && req_word);
endmodule

// ### tb/tb_interrupt_presentation_register.sv
// self-checking bench joining processor end and request word device
`timescale 1ns/1ps
`include "ipr_defs.svh"
module tb_interrupt_presentation_register;
	typedef struct {logic [7:0] cur; logic [23:0] id; logic [7:0] p; logic take;} row_s;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h00000000;
	logic write_strobe = 1'b0;
	logic read_strobe = 1'b0;
	logic offer_valid = 1'b0;
	logic [23:0] offer_id = 24'h000000;
	logic [7:0] offer_prio = 8'h00;
	logic [31:0] rdata, got;
	logic irq_out, offer_taken, offer_reject, reject_valid, completion_reset;
	logic [23:0] reject_id, completion_id, seen_rej, seen_comp;
	logic [7:0] completion_level;
	int err_total = 0;
	int n_tests = 0;
	row_s rows[5] = '{'{8'hFF, 24'h000123, 8'h10, 1'b1}, '{8'h10, 24'h000245, 8'h10, 1'b0},
		'{8'h10, 24'h000356, 8'h11, 1'b0}, '{8'h10, 24'h7FF467, 8'h0F, 1'b1},
		'{8'h80, 24'h000000, 8'h05, 1'b0}};
	ipr_if link ();
	request_word_device request_word_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.bus(link), .offer_valid(offer_valid), .offer_id(offer_id), .offer_prio(offer_prio),
		.offer_taken(offer_taken), .offer_reject(offer_reject), .reject_valid(reject_valid),
		.reject_id(reject_id), .completion_reset(completion_reset),
		.completion_id(completion_id), .completion_level(completion_level));
	processor_end processor_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(link),
		.addr(addr), .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.rdata(rdata), .irq_out(irq_out));
	request_word_checker request_word_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.req_load(link.req_load), .req_store(link.req_store),
		.req_accept_view(link.req_accept_view), .req_word(link.req_word),
		.req_data(link.req_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
		.int_line(link.int_line));
	// ==========================================================
	// clock and pulse capture
	always #12.5 ref_clk = ~ref_clk;
	// one-cycle pulses are latched so later checks can see them
	always @(posedge ref_clk) begin
		if (reject_valid) seen_rej <= reject_id;
		if (completion_reset) seen_comp <= completion_id;
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		write_strobe <= 1'b1;
		@(posedge ref_clk);
		write_strobe <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge ref_clk);
		addr <= a;
		read_strobe <= 1'b1;
		@(posedge ref_clk);
		read_strobe <= 1'b0;
		@(negedge ref_clk);
		got = rdata;
	endtask
	// 0 poll, 1 accept, 2 priority byte, 3 completion word; leaves result in got
	task automatic op(input logic [1:0] k, input logic [31:0] d);
		int i;
		wr(`CTL_DATA_ADDR, d);
		wr(`CTL_OP_ADDR, {30'h0, k});
		got = 32'h1;
		for (i = 0; i < 20 && got[`ST_BUSY_BIT] !== 1'b0; i++) rd(`CTL_STATUS_ADDR);
		rd(`CTL_RESULT_ADDR);
	endtask
	task automatic offer(input logic [23:0] id, input logic [7:0] p, input logic take);
		int i;
		@(posedge ref_clk);
		offer_valid <= 1'b1;
		offer_id <= id;
		offer_prio <= p;
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (i < 20 && offer_taken !== 1'b1 && offer_reject !== 1'b1);
		chk({31'h0, offer_taken}, {31'h0, take}, "offer taken");
		chk({31'h0, offer_reject}, {31'h0, ~take}, "offer refused");
		@(posedge ref_clk);
		offer_valid <= 1'b0;
		// let pulses captured at this edge settle before callers look
		@(negedge ref_clk);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// watchdog at 20000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#(25 * 20000);
		err_total++;
		results();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		op(2'h0, 32'h0);
		chk(got, 32'h00000000, "reset word");
		rd(5'h14);
		chk(got, 32'h00000000, "unmapped");
		foreach (rows[r]) begin
			op(2'h2, {rows[r].cur, 24'h000000});
			offer(rows[r].id, rows[r].p, rows[r].take);
			if (rows[r].take) begin
				rd(`CTL_STATUS_ADDR);
				chk(got[`ST_LINE_BIT], 1'b1, "line");
				repeat (2) begin
					op(2'h0, 32'h0);
					chk(got, {rows[r].cur, rows[r].id}, "poll");
				end
				op(2'h1, 32'h0);
				chk(got, {rows[r].cur, rows[r].id}, "accept");
				rd(`CTL_STATUS_ADDR);
				chk(got[5:0], 6'b010000, "status");
				op(2'h0, 32'h0);
				chk(got, {rows[r].p, 24'h000000}, "after accept");
				op(2'h3, {rows[r].cur, rows[r].id});
				chk(seen_comp, rows[r].id, "completion id");
				chk(completion_level, rows[r].cur, "level");
				op(2'h0, 32'h0);
				chk(got, {rows[r].cur, 24'h000000}, "after completion");
			end
		end
		// completion names another source; held identifier must survive
		wr(`CTL_ENABLE_ADDR, 32'h1);
		op(2'h2, {8'h80, 24'h000000});
		offer(24'h00A015, 8'h20, 1'b1);
		chk(irq_out, 1'b1, "irq");
		op(2'h3, {8'h80, 24'h00B021});
		chk(seen_comp, 24'h00B021, "other source");
		op(2'h0, 32'h0);
		chk(got, 32'h8000A015, "held id");
		op(2'h1, 32'h0);
		chk(irq_out, 1'b0, "irq cleared");
		// preemption before accept, then a fresh more favored offer
		op(2'h2, {8'h80, 24'h000000});
		offer(24'h00A015, 8'h40, 1'b1);
		offer(24'h00C032, 8'h20, 1'b1);
		chk(seen_rej, 24'h00A015, "preempted id");
		op(2'h1, 32'h0);
		chk(got, 32'h8000C032, "preempt accept");
		offer(24'h00D043, 8'h05, 1'b1);
		op(2'h1, 32'h0);
		chk(got, 32'h2000D043, "second accept");
		offer(24'h00E054, 8'h05, 1'b0);
		// rejection by a priority byte store leaves a spurious line
		op(2'h2, {8'h80, 24'h000000});
		offer(24'h00F065, 8'h20, 1'b1);
		op(2'h2, {8'h10, 24'h000000});
		chk(seen_rej, 24'h00F065, "rejected id");
		rd(`CTL_STATUS_ADDR);
		chk(got[`ST_LINE_BIT], 1'b1, "latched line");
		op(2'h1, 32'h0);
		chk(got, 32'h10000000, "spurious word");
		rd(`CTL_STATUS_ADDR);
		chk(got[`ST_SPURIOUS_BIT], 1'b1, "spurious flag");
		// enable write lands while the accept answer is still outstanding
		wr(`CTL_OP_ADDR, 32'h1);
		wr(`CTL_ENABLE_ADDR, 32'h1);
		repeat (6) @(posedge ref_clk);
		rd(`CTL_STATUS_ADDR);
		chk(got[`ST_ENABLE_BIT], 1'b0, "enable held off");
		// mid-run reset with a request presented
		offer(24'h00A015, 8'h08, 1'b1);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk({24'h0, completion_level}, 32'h000000FF, "level after reset");
		op(2'h0, 32'h0);
		chk(got, 32'h00000000, "word after reset");
		rd(`CTL_STATUS_ADDR);
		chk(got[5:0], 6'b000000, "status after reset");
		offer(24'h00A015, 8'h08, 1'b0);
		results();
	end
endmodule
